// ===== logic/dsr_debug_status_regs.sv
// Functional notes
// - Entry status read-only, causes latched at entry, bits 24 and 5 live
// - Simultaneous entry sources set all causes
// - Bit 28 trace-full entry, cleared exit
// - Bit 27 event-in entry, cleared exit
// - Bit 26 request or abort entry
// - Bit 25 zero-opcode entry, cleared exit
// - Bit 24 halted and idle in debug
// - Bits 15:8 per-breakpoint hit, cleared exit
// - Bit 5 in debug, not monitor
// - Bit 4 entered from sleep
// - Bit 3 hardware error forced entry
// - Bit 2 any hardware breakpoint entry
// - Bit 1 breakpoint instruction entry
// - Bit 0 single step entry
// - 32-bit read-write debug instruction register
// - Program counter tracks last non-debug instruction
// - In debug, counter holds pre-entry address until a debugger write
// - Replaced return uses counter as PC
// - Override mask kept until rewritten, reset
// - Mask bits 5:1 keep core features
// - Instruction replace fetches instruction, self-clears
// - Breakpoints, requests, steps need debug enable
`timescale 1ns/100ps
module dsr_debug_status_regs (
	// Clock and reset
	input  wire logic                       ref_clk,
	input  wire logic                       reset,
	// Debug port register access
	input  wire logic [dsr_pkg::ADDR_W-1:0] regAddr,
	input  wire logic                       regWrite,
	input  wire logic                       regRead,
	input  wire logic [31:0]                regWriteData,
	output logic [31:0]                     regReadData,
	output logic                            regReadValid,
	// Control register bits held outside, except instruction replace, which is held here
	input  wire logic                       debugEnableBit,
	input  wire logic                       irpWrite,
	input  wire logic                       irpWriteValue,
	input  wire logic                       systemResetRequest,
	output logic                            instructionReplace,
	// Entry sources from core
	input  wire dsr_pkg::dsr_cause_s        entrySources,
	input  wire logic                       coreSleeping,
	// Core debug execution
	input  wire logic                       execStart,
	input  wire logic                       execDone,
	input  wire logic                       debugReturn,
	input  wire logic                       retireValid,
	input  wire logic [31:0]                retirePc,
	// Towards core
	output logic                            inDebugIndicator,
	output logic                            debugEntry,
	output logic                            fetchFromInstruction,
	output logic [31:0]                     debugInstruction,
	output logic [31:0]                     replacePc,
	output dsr_pkg::dsr_keep_s              keepFeatures
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	dsr_pkg::dsr_state_e state_reg;
	dsr_pkg::dsr_state_e state_next;
	logic [31:0]         instruction_reg;
	logic [31:0]         instruction_next;
	logic [31:0]         mask_reg;
	logic [31:0]         mask_next;
	logic                irp_reg;
	logic                irp_next;
	logic [31:0]         readData_reg;
	logic [31:0]         readData_next;
	logic                readValid_reg;
	logic                fetch_reg;
	logic                fetch_next;
	dsr_pkg::dsr_cause_s gatedSources;
	dsr_pkg::dsr_cause_s causeHeld;
	logic                fromSleepHeld;
	logic                anySource;
	logic                entryPulse;
	logic                exitPulse;
	logic                inDebug;
	logic                haltedIdle;
	logic                hwBreakHeld;
	logic [31:0]         statusWord;
	logic [31:0]         pcValue;
	logic                selStatus;
	logic                selInstr;
	logic                selPc;
	logic                selMask;
	logic                wrInstr;
	logic                wrPc;
	logic                wrMask;

	// ****************************************************************
	// Entry source qualification
	// ****************************************************************
	// gate enabled-only sources
	assign gatedSources.breakpointHit   = entrySources.breakpointHit
	                                      & {dsr_pkg::BP_COUNT{debugEnableBit}};
	assign gatedSources.requestAck      = entrySources.requestAck & debugEnableBit;
	assign gatedSources.singleStep      = entrySources.singleStep & debugEnableBit;
	assign gatedSources.externalEvent   = entrySources.externalEvent & debugEnableBit;
	assign gatedSources.swBreakpoint    = entrySources.swBreakpoint & debugEnableBit;
	assign gatedSources.zeroOpcode      = entrySources.zeroOpcode & debugEnableBit;
	// Hardware faults and trace overflow force entry regardless
	assign gatedSources.traceBufferFull = entrySources.traceBufferFull;
	assign gatedSources.hardwareError   = entrySources.hardwareError;

	assign anySource  = |gatedSources;
	assign entryPulse = (state_reg == dsr_pkg::ST_RUN) & anySource;
	assign exitPulse  = (state_reg == dsr_pkg::ST_RETURN);

	// ****************************************************************
	// Debug mode sequencer
	// ****************************************************************
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			dsr_pkg::ST_RUN: begin
				if (anySource) begin
					state_next = dsr_pkg::ST_HALTED;
				end
			end
			dsr_pkg::ST_HALTED: begin
				if (debugReturn) begin
					state_next = dsr_pkg::ST_RETURN;
				end else if (execStart) begin
					state_next = dsr_pkg::ST_EXEC;
				end
			end
			dsr_pkg::ST_EXEC: begin
				if (execDone) begin
					state_next = dsr_pkg::ST_HALTED;
				end
			end
			dsr_pkg::ST_RETURN: begin
				state_next = dsr_pkg::ST_RUN;
			end
			default: begin
				state_next = dsr_pkg::ST_RUN;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_reg <= dsr_pkg::ST_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	assign inDebug    = (state_reg != dsr_pkg::ST_RUN);
	assign haltedIdle = (state_reg == dsr_pkg::ST_HALTED);

	// ****************************************************************
	// Cause capture
	// ****************************************************************
	dsr_cause_capture u_cause (
		.ref_clk       (ref_clk),
		.reset         (reset),
		.entryPulse    (entryPulse),
		.exitPulse     (exitPulse),
		.causeIn       (gatedSources),
		.sleepIn       (coreSleeping),
		.causeHeld     (causeHeld),
		.fromSleepHeld (fromSleepHeld)
	);

	assign hwBreakHeld = |causeHeld.breakpointHit;

	// ****************************************************************
	// Entry status word
	// ****************************************************************
	// composed from state, never cleared by software
	always_comb begin
		statusWord = dsr_pkg::RST_ENTRY_STATUS;
		statusWord[dsr_pkg::POS_TRACE_FULL]  = causeHeld.traceBufferFull;
		statusWord[dsr_pkg::POS_EXT_EVENT]   = causeHeld.externalEvent;
		statusWord[dsr_pkg::POS_REQUEST_ACK] = causeHeld.requestAck;
		statusWord[dsr_pkg::POS_ZERO_OPCODE] = causeHeld.zeroOpcode;
		statusWord[dsr_pkg::POS_HALTED_IDLE] = haltedIdle;
		statusWord[dsr_pkg::POS_BP_LO +: dsr_pkg::BP_COUNT] = causeHeld.breakpointHit;
		statusWord[dsr_pkg::POS_IN_DEBUG]    = inDebug;
		statusWord[dsr_pkg::POS_FROM_SLEEP]  = fromSleepHeld;
		statusWord[dsr_pkg::POS_HW_ERROR]    = causeHeld.hardwareError;
		statusWord[dsr_pkg::POS_HW_BREAK]    = hwBreakHeld;
		statusWord[dsr_pkg::POS_SW_BREAK]    = causeHeld.swBreakpoint;
		statusWord[dsr_pkg::POS_SINGLE_STEP] = causeHeld.singleStep;
	end

	// ****************************************************************
	// Address decode
	// ****************************************************************
	assign selStatus = (regAddr == dsr_pkg::IDX_ENTRY_STATUS);
	assign selInstr  = (regAddr == dsr_pkg::IDX_INSTRUCTION);
	assign selPc     = (regAddr == dsr_pkg::IDX_PROGRAM_CNT);
	assign selMask   = (regAddr == dsr_pkg::IDX_OVERRIDE_MASK);
	// Status is read-only; writes to it are dropped
	assign wrInstr   = regWrite & selInstr;
	assign wrPc      = regWrite & selPc;
	assign wrMask    = regWrite & selMask;

	// ****************************************************************
	// Writable registers
	// ****************************************************************
	// full-width instruction holder
	assign instruction_next = wrInstr ? regWriteData : instruction_reg;
	// kept until next write or reset
	assign mask_next        = wrMask ? (regWriteData & dsr_pkg::MASK_WRITABLE) : mask_reg;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			instruction_reg <= dsr_pkg::RST_INSTRUCTION;
			mask_reg        <= dsr_pkg::RST_OVERRIDE_MASK;
		end else begin
			instruction_reg <= instruction_next;
			mask_reg        <= mask_next;
		end
	end

	dsr_pc_tracker u_pc (
		.ref_clk     (ref_clk),
		.reset       (reset),
		.retireValid (retireValid),
		.retirePc    (retirePc),
		.inDebug     (inDebug),
		.pcWrite     (wrPc),
		.pcWriteData (regWriteData),
		.pcValue     (pcValue)
	);

	// ****************************************************************
	// Instruction replace on return
	// ****************************************************************
	// write ignored alongside system reset; clears on return, same edge that raises fetch
	assign irp_next   = exitPulse                           ? 1'b0          :
	                    (irpWrite & ~systemResetRequest)    ? irpWriteValue : irp_reg;
	assign fetch_next = exitPulse & irp_reg;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			irp_reg   <= 1'b0;
			fetch_reg <= 1'b0;
		end else begin
			irp_reg   <= irp_next;
			fetch_reg <= fetch_next;
		end
	end

	// ****************************************************************
	// Read port
	// ****************************************************************
	assign readData_next = ~regRead  ? readData_reg    :
	                       selStatus ? statusWord      :
	                       selInstr  ? instruction_reg :
	                       selPc     ? pcValue         :
	                       selMask   ? mask_reg        : dsr_pkg::READ_UNMAPPED;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			readData_reg  <= dsr_pkg::READ_UNMAPPED;
			readValid_reg <= 1'b0;
		end else begin
			readData_reg  <= readData_next;
			readValid_reg <= regRead;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign regReadData          = readData_reg;
	assign regReadValid         = readValid_reg;
	assign instructionReplace   = irp_reg;
	assign inDebugIndicator     = inDebug;
	assign debugEntry           = entryPulse;
	assign fetchFromInstruction = fetch_reg;
	assign debugInstruction     = instruction_reg;
	// counter supplies PC of replaced return
	assign replacePc            = pcValue;
	assign keepFeatures.keepImpreciseExec    = mask_reg[dsr_pkg::POS_KEEP_IMP_EXEC];
	assign keepFeatures.keepImprecisePcBreak = mask_reg[dsr_pkg::POS_KEEP_IMP_PCBRK];
	assign keepFeatures.keepReturnStack      = mask_reg[dsr_pkg::POS_KEEP_RET_STACK];
	assign keepFeatures.keepBranchFolding    = mask_reg[dsr_pkg::POS_KEEP_FOLDING];
	assign keepFeatures.keepBranchPrediction = mask_reg[dsr_pkg::POS_KEEP_PREDICT];

endmodule

// ===== include/dsr_pkg.sv
package dsr_pkg;

	// ****************************************************************
	// Register indices on the debug-port register access
	// ****************************************************************
	localparam int          ADDR_W            = 4;
	localparam logic [3:0]  IDX_ENTRY_STATUS  = 4'h0;
	localparam logic [3:0]  IDX_INSTRUCTION   = 4'h1;
	localparam logic [3:0]  IDX_PROGRAM_CNT   = 4'h2;
	localparam logic [3:0]  IDX_OVERRIDE_MASK = 4'h3;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [31:0] RST_ENTRY_STATUS  = 32'h0000_0000;
	localparam logic [31:0] RST_INSTRUCTION   = 32'h0000_0000;
	localparam logic [31:0] RST_PROGRAM_CNT   = 32'h0000_0000;
	localparam logic [31:0] RST_OVERRIDE_MASK = 32'h0000_0000;
	localparam logic [31:0] READ_UNMAPPED     = 32'h0000_0000;

	// ****************************************************************
	// Entry status field positions
	// ****************************************************************
	localparam int POS_TRACE_FULL   = 28;
	localparam int POS_EXT_EVENT    = 27;
	localparam int POS_REQUEST_ACK  = 26;
	localparam int POS_ZERO_OPCODE  = 25;
	localparam int POS_HALTED_IDLE  = 24;
	localparam int POS_BP_LO        = 8;
	localparam int BP_COUNT         = 8;
	localparam int POS_IN_DEBUG     = 5;
	localparam int POS_FROM_SLEEP   = 4;
	localparam int POS_HW_ERROR     = 3;
	localparam int POS_HW_BREAK     = 2;
	localparam int POS_SW_BREAK     = 1;
	localparam int POS_SINGLE_STEP  = 0;

	// ****************************************************************
	// Override mask field positions
	// ****************************************************************
	localparam int          POS_KEEP_IMP_EXEC  = 5;
	localparam int          POS_KEEP_IMP_PCBRK = 4;
	localparam int          POS_KEEP_RET_STACK = 3;
	localparam int          POS_KEEP_FOLDING   = 2;
	localparam int          POS_KEEP_PREDICT   = 1;
	localparam logic [31:0] MASK_WRITABLE      = 32'h0000_003E;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef struct packed {
		logic                traceBufferFull;
		logic                externalEvent;
		logic                requestAck;
		logic                zeroOpcode;
		logic                hardwareError;
		logic                swBreakpoint;
		logic                singleStep;
		logic [BP_COUNT-1:0] breakpointHit;
	} dsr_cause_s;

	typedef struct packed {
		logic keepImpreciseExec;
		logic keepImprecisePcBreak;
		logic keepReturnStack;
		logic keepBranchFolding;
		logic keepBranchPrediction;
	} dsr_keep_s;

	// Gray codes along run, halt, execute, halt; halt to return flips both bits
	typedef enum logic [1:0] {
		ST_RUN    = 2'b00,
		ST_HALTED = 2'b01,
		ST_EXEC   = 2'b11,
		ST_RETURN = 2'b10
	} dsr_state_e;

endpackage

// ===== logic/dsr_cause_capture.sv
`timescale 1ns/100ps
module dsr_cause_capture (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             reset,
	// Entry and exit
	input  wire logic             entryPulse,
	input  wire logic             exitPulse,
	input  wire dsr_pkg::dsr_cause_s causeIn,
	input  wire logic             sleepIn,
	// Held causes
	output dsr_pkg::dsr_cause_s   causeHeld,
	output logic                  fromSleepHeld
);

	dsr_pkg::dsr_cause_s causeHeld_reg;
	dsr_pkg::dsr_cause_s causeHeld_next;
	logic                fromSleep_reg;
	logic                fromSleep_next;

	// ****************************************************************
	// Capture on entry, clear on exit
	// ****************************************************************
	// all simultaneous causes
	assign causeHeld_next = entryPulse ? causeIn :
	                        exitPulse  ? '0      : causeHeld_reg;
	assign fromSleep_next = entryPulse ? sleepIn :
	                        exitPulse  ? 1'b0    : fromSleep_reg;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			causeHeld_reg <= '0;
			fromSleep_reg <= 1'b0;
		end else begin
			causeHeld_reg <= causeHeld_next;
			fromSleep_reg <= fromSleep_next;
		end
	end

	assign causeHeld     = causeHeld_reg;
	assign fromSleepHeld = fromSleep_reg;

endmodule

// ===== logic/dsr_pc_tracker.sv
`timescale 1ns/100ps
module dsr_pc_tracker (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        reset,
	// Core retire
	input  wire logic        retireValid,
	input  wire logic [31:0] retirePc,
	input  wire logic        inDebug,
	// Debugger write
	input  wire logic        pcWrite,
	input  wire logic [31:0] pcWriteData,
	// Value
	output logic [31:0]      pcValue
);

	logic [31:0] pc_reg;
	logic [31:0] pc_next;
	logic        takeRetire;

	// ****************************************************************
	// Last executed non-debug PC
	// ****************************************************************
	// follow retires outside debug
	assign takeRetire = retireValid & ~inDebug;
	// Debugger write loses to a live retire; retires are ignored in debug, where it always lands
	assign pc_next    = takeRetire ? retirePc :
	                    pcWrite    ? pcWriteData : pc_reg;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pc_reg <= dsr_pkg::RST_PROGRAM_CNT;
		end else begin
			pc_reg <= pc_next;
		end
	end

	assign pcValue = pc_reg;

endmodule

// ===== bench/dsr_debug_status_chk.sv
`timescale 1ns/100ps
// ****************************************************************
// Port checker
// ****************************************************************
module dsr_debug_status_chk (
	// Clock and reset
	input wire logic                       ref_clk,
	input wire logic                       reset,
	// Register access
	input wire logic [dsr_pkg::ADDR_W-1:0] regAddr,
	input wire logic                       regWrite,
	input wire logic                       regRead,
	input wire logic [31:0]                regWriteData,
	input wire logic                       regReadValid,
	// Core side
	input wire logic                       debugEnableBit,
	input wire logic                       instructionReplace,
	input wire dsr_pkg::dsr_cause_s        entrySources,
	input wire logic                       debugReturn,
	input wire logic                       retireValid,
	input wire logic [31:0]                retirePc,
	input wire logic                       inDebugIndicator,
	input wire logic                       debugEntry,
	input wire logic                       fetchFromInstruction,
	input wire logic [31:0]                debugInstruction,
	input wire logic [31:0]                replacePc,
	input wire dsr_pkg::dsr_keep_s         keepFeatures
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);

	wire maskWrite = regWrite && regAddr == dsr_pkg::IDX_OVERRIDE_MASK;
	wire pcWrite   = regWrite && regAddr == dsr_pkg::IDX_PROGRAM_CNT;

	sequence sRetReplace;
		inDebugIndicator && debugReturn && instructionReplace;
	endsequence
	sequence sFetchOut;
		fetchFromInstruction && !instructionReplace && !inDebugIndicator;
	endsequence

	AST_READ_ANSWER: assert property (regRead |=> regReadValid)
		else $error("read not answered");
	AST_READ_PULSE: assert property (!regRead |=> !regReadValid)
		else $error("read valid without read");
	AST_ENTRY_HALTS: assert property (debugEntry |=> inDebugIndicator)
		else $error("entry did not reach debug");
	AST_ENTRY_FROM_RUN: assert property (inDebugIndicator |-> !debugEntry)
		else $error("entry while in debug");
	AST_ENTRY_GATED: assert property (debugEntry && !debugEnableBit |->
		entrySources.hardwareError || entrySources.traceBufferFull)
		else $error("gated source entered debug");
	AST_INSTR_WRITE: assert property (regWrite && regAddr == dsr_pkg::IDX_INSTRUCTION
		|=> debugInstruction == $past(regWriteData)) else $error("instruction not written");
	AST_MASK_WRITE: assert property (maskWrite |=> keepFeatures == $past(regWriteData[5:1]))
		else $error("mask bits misplaced");
	AST_MASK_HOLD: assert property (!maskWrite |=> $stable(keepFeatures))
		else $error("mask changed without write");
	AST_PC_TRACK: assert property (retireValid && !inDebugIndicator
		|=> replacePc == $past(retirePc)) else $error("pc not tracked");
	AST_PC_HELD: assert property (inDebugIndicator && !pcWrite |=> $stable(replacePc))
		else $error("pc moved in debug");
	AST_REPLACE_FETCH: assert property (sRetReplace |-> ##2 sFetchOut)
		else $error("replace fetch missing");
endmodule

bind dsr_debug_status_regs dsr_debug_status_chk u_chk (
	.ref_clk(ref_clk), .reset(reset), .regAddr(regAddr), .regWrite(regWrite),
	.regRead(regRead), .regWriteData(regWriteData), .regReadValid(regReadValid),
	.debugEnableBit(debugEnableBit), .instructionReplace(instructionReplace),
	.entrySources(entrySources), .debugReturn(debugReturn), .retireValid(retireValid),
	.retirePc(retirePc), .inDebugIndicator(inDebugIndicator), .debugEntry(debugEntry),
	.fetchFromInstruction(fetchFromInstruction), .debugInstruction(debugInstruction),
	.replacePc(replacePc), .keepFeatures(keepFeatures)
);

// ===== bench/dsr_debugger_model.sv
`timescale 1ns/100ps
// ****************************************************************
// Debugger side of the register access
// ****************************************************************
module dsr_debugger_model (
	// Clock
	input wire logic                       ref_clk,
	// Register access
	output logic [dsr_pkg::ADDR_W-1:0]     regAddr,
	output logic                           regWrite,
	output logic                           regRead,
	output logic [31:0]                    regWriteData,
	input wire logic [31:0]                regReadData,
	input wire logic                       regReadValid
);
	initial begin
		regAddr = 4'h0;
		regWrite = 1'b0;
		regRead = 1'b0;
		regWriteData = 32'h0000_0000;
	end

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(negedge ref_clk);
		regAddr = a;
		regWriteData = d;
		regWrite = 1'b1;
		@(negedge ref_clk);
		regWrite = 1'b0;
		// Stale data inverted so a late sample cannot pass
		regWriteData = ~d;
	endtask

	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		int i;
		@(negedge ref_clk);
		regAddr = a;
		regRead = 1'b1;
		@(negedge ref_clk);
		regRead = 1'b0;
		for (i = 0; i < 4 && regReadValid !== 1'b1; i++) begin
			@(negedge ref_clk);
		end
		if (i == 4) begin
			$display("[ERR] %0t read answer timed out", $time);
			tb_top.n_errors++;
			tb_top.print_verdict();
		end
		d = regReadData;
	endtask
endmodule

// ===== bench/tb_top.sv
`timescale 1ns/100ps
// ****************************************************************
// Testbench
// ****************************************************************
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_errors++; \
	$display("[ERR] %0t got %h exp %h", $time, got, exp); end end
module tb_top;
	logic ref_clk, reset, debugEnableBit, irpWrite, irpWriteValue, systemResetRequest;
	logic coreSleeping, execStart, execDone, debugReturn, retireValid, f;
	logic [31:0] retirePc, rdat;
	dsr_pkg::dsr_cause_s entrySources, c;
	wire logic [3:0] regAddr;
	wire logic regWrite, regRead, regReadValid, instructionReplace, inDebugIndicator;
	wire logic debugEntry, fetchFromInstruction;
	wire logic [31:0] regWriteData, regReadData, debugInstruction, replacePc;
	dsr_pkg::dsr_keep_s keepFeatures;
	int n_errors, total_checks, i;

	dsr_debugger_model u_dbg (.ref_clk(ref_clk), .regAddr(regAddr), .regWrite(regWrite),
		.regRead(regRead), .regWriteData(regWriteData), .regReadData(regReadData),
		.regReadValid(regReadValid));
	dsr_debug_status_regs u_dut (.ref_clk(ref_clk), .reset(reset), .regAddr(regAddr),
		.regWrite(regWrite), .regRead(regRead), .regWriteData(regWriteData),
		.regReadData(regReadData), .regReadValid(regReadValid),
		.debugEnableBit(debugEnableBit), .irpWrite(irpWrite), .irpWriteValue(irpWriteValue),
		.systemResetRequest(systemResetRequest), .instructionReplace(instructionReplace),
		.entrySources(entrySources), .coreSleeping(coreSleeping), .execStart(execStart),
		.execDone(execDone), .debugReturn(debugReturn), .retireValid(retireValid),
		.retirePc(retirePc), .inDebugIndicator(inDebugIndicator), .debugEntry(debugEntry),
		.fetchFromInstruction(fetchFromInstruction), .debugInstruction(debugInstruction),
		.replacePc(replacePc), .keepFeatures(keepFeatures));

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	task print_verdict;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	task rdchk(input logic [3:0] a, input logic [31:0] e);
		u_dbg.rd(a, rdat);
		`CHK(rdat, e)
	endtask

	function automatic logic [31:0] expStat(input dsr_pkg::dsr_cause_s s, input logic slp,
		input logic idle);
		expStat = {3'h0, s.traceBufferFull, s.externalEvent, s.requestAck, s.zeroOpcode, idle,
			8'h00, s.breakpointHit, 2'h0, 1'b1, slp, s.hardwareError, |s.breakpointHit,
			s.swBreakpoint, s.singleStep};
	endfunction

	task enter(input dsr_pkg::dsr_cause_s s, input logic slp);
		@(negedge ref_clk);
		entrySources = s;
		coreSleeping = slp;
		@(negedge ref_clk);
		entrySources = '0;
		coreSleeping = 1'b0;
	endtask

	task pulse(input int which);
		@(negedge ref_clk);
		{execStart, execDone, retireValid, irpWrite} = 4'h1 << which;
		@(negedge ref_clk);
		{execStart, execDone, retireValid, irpWrite} = 4'h0;
	endtask

	task leave;
		@(negedge ref_clk);
		debugReturn = 1'b1;
		@(negedge ref_clk);
		debugReturn = 1'b0;
		@(negedge ref_clk);
		f = fetchFromInstruction;
		@(negedge ref_clk);
	endtask

	initial begin
		{reset, debugEnableBit, irpWrite, irpWriteValue, systemResetRequest} = 5'h10;
		{coreSleeping, execStart, execDone, debugReturn, retireValid} = 5'h00;
		retirePc = 32'h0000_0000;
		entrySources = '0;
		repeat (4) @(posedge ref_clk);
		@(negedge ref_clk);
		reset = 1'b0;
		for (i = 0; i < 6; i++) rdchk(i[3:0], 32'h0000_0000);
		u_dbg.wr(dsr_pkg::IDX_ENTRY_STATUS, 32'hFFFF_FFFF);
		rdchk(dsr_pkg::IDX_ENTRY_STATUS, 32'h0000_0000);
		u_dbg.wr(dsr_pkg::IDX_INSTRUCTION, 32'hA5C3_0F96);
		rdchk(dsr_pkg::IDX_INSTRUCTION, 32'hA5C3_0F96);
		u_dbg.wr(dsr_pkg::IDX_OVERRIDE_MASK, 32'hFFFF_FFFF);
		u_dbg.wr(dsr_pkg::IDX_PROGRAM_CNT, 32'h0000_1000);
		rdchk(dsr_pkg::IDX_OVERRIDE_MASK, dsr_pkg::MASK_WRITABLE);
		u_dbg.wr(dsr_pkg::IDX_OVERRIDE_MASK, 32'h0000_0014);
		`CHK(keepFeatures, 5'h0A)
		`CHK(replacePc, 32'h0000_1000)
		retirePc = 32'h0000_2468;
		pulse(1);
		rdchk(dsr_pkg::IDX_PROGRAM_CNT, 32'h0000_2468);
		$display("registers done");
		// Every cause alone, sleep alternating
		debugEnableBit = 1'b1;
		for (i = 0; i < 15; i++) begin
			c = 15'h0001 << i;
			enter(c, i[0]);
			rdchk(dsr_pkg::IDX_ENTRY_STATUS, expStat(c, i[0], 1'b1));
			retirePc = 32'hDEAD_0000 + i;
			pulse(1);
			rdchk(dsr_pkg::IDX_PROGRAM_CNT, 32'h0000_2468);
			leave();
			`CHK(f, 1'b0)
			// Status trusted only in debug, zero is the chosen idle reading
			rdchk(dsr_pkg::IDX_ENTRY_STATUS, 32'h0000_0000);
		end
		$display("single causes done");
		c = 15'h7FFF;
		enter(c, 1'b1);
		rdchk(dsr_pkg::IDX_ENTRY_STATUS, expStat(c, 1'b1, 1'b1));
		pulse(3);
		rdchk(dsr_pkg::IDX_ENTRY_STATUS, expStat(c, 1'b1, 1'b0));
		enter(15'h0001, 1'b0);
		pulse(2);
		rdchk(dsr_pkg::IDX_ENTRY_STATUS, expStat(c, 1'b1, 1'b1));
		{irpWriteValue, systemResetRequest} = 2'b11;
		pulse(0);
		`CHK(instructionReplace, 1'b0)
		systemResetRequest = 1'b0;
		pulse(0);
		`CHK(instructionReplace, 1'b1)
		leave();
		`CHK(f, 1'b1)
		`CHK(instructionReplace, 1'b0)
		$display("multi cause and replace done");
		debugEnableBit = 1'b0;
		c = '0;
		c.requestAck = 1'b1;
		enter(c, 1'b0);
		`CHK(inDebugIndicator, 1'b0)
		c = '0;
		c.hardwareError = 1'b1;
		enter(c, 1'b0);
		rdchk(dsr_pkg::IDX_ENTRY_STATUS, expStat(c, 1'b0, 1'b1));
		// Debugger answers an error by asking for a system reset
		systemResetRequest = 1'b1;
		leave();
		systemResetRequest = 1'b0;
		$display("gating and error done");
		// Mid-run reset must drop the kept mask
		reset = 1'b1;
		@(negedge ref_clk);
		reset = 1'b0;
		`CHK(keepFeatures, 5'h00)
		rdchk(dsr_pkg::IDX_OVERRIDE_MASK, dsr_pkg::RST_OVERRIDE_MASK);
		rdchk(dsr_pkg::IDX_ENTRY_STATUS, dsr_pkg::RST_ENTRY_STATUS);
		$display("mid-run reset done");
		print_verdict();
	end
endmodule
